/* hdl/aiwc_params.svh */
// Offsets, field positions, reset values and timing counts of the analog input block.
// Assumes inclusion by the block and the bench; holds definitions only.
`ifndef AIWC_PARAMS_SVH
`define AIWC_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AIWC_CTRL 8'h00
`define AIWC_SMIN 8'h04
`define AIWC_SMAX 8'h08
`define AIWC_SMIN2 8'h0c
`define AIWC_SMAX2 8'h10
`define AIWC_WHI 8'h14
`define AIWC_WLO 8'h18
`define AIWC_HYST 8'h1c
`define AIWC_THR1 8'h20
`define AIWC_THR2 8'h24
`define AIWC_DEV 8'h28
`define AIWC_TMO 8'h2c
`define AIWC_LIMIT 8'h30
`define AIWC_STATUS 8'h34
`define AIWC_VALUE 8'h38
// ----------------------------------------
// Control fields
// ----------------------------------------
`define AIWC_F_TYPE 1:0
`define AIWC_F_CHAN 3:2
`define AIWC_F_RED12 4
`define AIWC_F_RED34 5
`define AIWC_F_DIFF 6
`define AIWC_F_CONS 9:7
`define AIWC_F_WIN 10
`define AIWC_F_THR1 11
`define AIWC_F_THR2 12
`define AIWC_F_SAT25 13
`define AIWC_F_ERREN 14
// ----------------------------------------
// Reset values
// ----------------------------------------
`define AIWC_CTRL_RST 32'h0000_0000
`define AIWC_LIMIT_RST 32'h59d8_09c4
`define AIWC_SMAX_RST 32'h0000_03e8
// ----------------------------------------
// Raw scale points, microamps or millivolts
// ----------------------------------------
`define AIWC_RAW_4MA 32'sd4000
`define AIWC_RAW_20MA 32'sd20000
`define AIWC_RAW_10V 32'sd10000
`define AIWC_RAW_SAT 16'd25000
// ----------------------------------------
// Timing
// ----------------------------------------
`define AIWC_CLK_NS 8
`define AIWC_TICK_NS 1000000
`define AIWC_TICK_CYC (`AIWC_TICK_NS / `AIWC_CLK_NS)
`endif

/* hdl/aiwc_pkg.sv */
// Types shared by the analog input block.
// Assumes aiwc_params.svh alongside.
package aiwc_pkg;
   typedef enum logic [1:0] {AIWC_I4_20, AIWC_I0_20, AIWC_V0_10} aiwc_type_t;
   typedef enum logic [2:0] {AIWC_C_MAIN, AIWC_C_RED, AIWC_C_MAX, AIWC_C_MIN, AIWC_C_AVG}
      aiwc_cons_t;
   typedef enum {AIWC_OUT_WIN, AIWC_IN_WIN} aiwc_win_t;
   typedef enum {AIWC_UNDER, AIWC_OVER} aiwc_thr_t;
   typedef struct packed {
      logic valid;
      logic [3:0] anomaly;
      logic [3:0][15:0] raw;
   } aiwc_samp_t;
endpackage : aiwc_pkg

/* hdl/aiwc_block.sv */
// Analog input block: scaling, redundancy check, consolidation, comparators, APB registers.
// Assumes raw samples in microamps or millivolts, synchronous to MCLK, one valid pulse each.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "aiwc_params.svh"

// Operation
// - Sensor type is 0-20 mA, 4-20 mA or 0-10 V
// - Window comparator or two threshold comparators, never both
// - Single mode takes one sensor from any channel 1 to 4
// - Redundant mode pairs channels 1-2 or 3-4 in one block
// - Pair 1-2 and pair 3-4 each set single or redundant independently
// - Redundant readings compared against a maximum deviation in user units
// - Deviation may exceed limit at most a configurable timeout
// - Identical sensors compared on one scale
// - Different sensors: second reading rescaled to first scale before difference
// - Consolidation can pick primary or redundant value
// - Consolidation can pick maximum or minimum value
// - Consolidation can pick arithmetic mean
// - Consolidated value feeds comparators and analog data output
// - Scale minimum maps to 4 mA, 0 mA or 0 V
// - Scale maximum maps to 20 mA or 10 V
// - Linear transfer from scale minimum and maximum
// - Window comparator uses high, low and hysteresis, one output
// - Window is two states, output 1 in window, 0 out
// - Enter window above low and below high minus hysteresis
// - Stay in window below high and above low plus hysteresis
// - Threshold comparator with hysteresis on fall
// - Diagnostic when current below minimum or above maximum limit
// - Sensor anomaly forces measurement to 0 mA or 25 mA
// - Error output high while anomaly present, when enabled
module aiwc_block import aiwc_pkg::*; #(
   parameter int TICK_CYC = `AIWC_TICK_CYC
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire aiwc_samp_t SAMPLE,
   output logic [31:0] ANALOG_DATA,
   output logic ANALOG_VALID,
   output logic COMPARATOR_OUTPUT_ONE,
   output logic COMPARATOR_OUTPUT_TWO,
   output logic ERROR_OUT,
   output logic DIAG_OUT,
   output logic INCOHERENT_OUT
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] ctrl_q, smin_q, smax_q, smin2_q, smax2_q, whi_q, wlo_q, hyst_q;
   logic [31:0] thr1_q, thr2_q, dev_q, tmo_q, limit_q;
   logic pready_q, pslverr_q, hit, wr;
   logic [31:0] prdata_q, rd_d;
   aiwc_type_t typ;
   logic redundant;
   logic [1:0] ch_a, ch_b;
   assign typ = aiwc_type_t'(ctrl_q[`AIWC_F_TYPE]);
   // Pair config lives per channel pair, so pairs never mix modes
   assign redundant = ctrl_q[`AIWC_F_CHAN] < 2'd2 ? ctrl_q[`AIWC_F_RED12]
                                                  : ctrl_q[`AIWC_F_RED34];
   assign ch_a = redundant ? {ctrl_q[3], 1'b0} : ctrl_q[`AIWC_F_CHAN];
   assign ch_b = {ctrl_q[3], 1'b1};
   assign wr = PSEL & PENABLE & PWRITE & pready_q;
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ctrl_q <= `AIWC_CTRL_RST;
         smin_q <= 32'h0;
         smax_q <= `AIWC_SMAX_RST;
         smin2_q <= 32'h0;
         smax2_q <= `AIWC_SMAX_RST;
         whi_q <= 32'h0;
         wlo_q <= 32'h0;
         hyst_q <= 32'h0;
         thr1_q <= 32'h0;
         thr2_q <= 32'h0;
         dev_q <= 32'h0;
         tmo_q <= 32'h0;
         limit_q <= `AIWC_LIMIT_RST;
      end else if (wr) begin
         unique case (PADDR)
            `AIWC_CTRL: ctrl_q <= PWDATA;
            `AIWC_SMIN: smin_q <= PWDATA;
            `AIWC_SMAX: smax_q <= PWDATA;
            `AIWC_SMIN2: smin2_q <= PWDATA;
            `AIWC_SMAX2: smax2_q <= PWDATA;
            `AIWC_WHI: whi_q <= PWDATA;
            `AIWC_WLO: wlo_q <= PWDATA;
            `AIWC_HYST: hyst_q <= PWDATA;
            `AIWC_THR1: thr1_q <= PWDATA;
            `AIWC_THR2: thr2_q <= PWDATA;
            `AIWC_DEV: dev_q <= PWDATA;
            `AIWC_TMO: tmo_q <= PWDATA;
            `AIWC_LIMIT: limit_q <= PWDATA;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // APB answer, no wait states, registered
   // ----------------------------------------
   always_comb begin
      hit = 1'b1;
      rd_d = 32'h0;
      unique case (PADDR)
         `AIWC_CTRL: rd_d = ctrl_q;
         `AIWC_SMIN: rd_d = smin_q;
         `AIWC_SMAX: rd_d = smax_q;
         `AIWC_SMIN2: rd_d = smin2_q;
         `AIWC_SMAX2: rd_d = smax2_q;
         `AIWC_WHI: rd_d = whi_q;
         `AIWC_WLO: rd_d = wlo_q;
         `AIWC_HYST: rd_d = hyst_q;
         `AIWC_THR1: rd_d = thr1_q;
         `AIWC_THR2: rd_d = thr2_q;
         `AIWC_DEV: rd_d = dev_q;
         `AIWC_TMO: rd_d = tmo_q;
         `AIWC_LIMIT: rd_d = limit_q;
         `AIWC_STATUS: rd_d = {26'h0, INCOHERENT_OUT, DIAG_OUT, ERROR_OUT,
                               COMPARATOR_OUTPUT_TWO, COMPARATOR_OUTPUT_ONE, ANALOG_VALID};
         `AIWC_VALUE: rd_d = ANALOG_DATA;
         default: hit = 1'b0;
      endcase
   end
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= PSEL & ~PENABLE;
         pslverr_q <= PSEL & ~PENABLE & ~hit;
         if (PSEL & ~PENABLE) prdata_q <= rd_d;
      end
   end
   assign {PREADY, PSLVERR, PRDATA} = {pready_q, pslverr_q, prdata_q};

   // ----------------------------------------
   // Stage 1: saturation, limits, scaling
   // ----------------------------------------
   // Span is one of three constants, so the divide stays a constant divide
   function automatic logic signed [31:0] scale(input logic [15:0] raw, input aiwc_type_t t,
         input logic signed [31:0] lo, input logic signed [31:0] hi);
      logic signed [47:0] prod;
      logic signed [31:0] rmin;
      rmin = (t == AIWC_I4_20) ? `AIWC_RAW_4MA : 32'sd0;
      prod = 48'($signed({1'b0, raw}) - rmin) * 48'(hi - lo);
      unique case (t)
         AIWC_I4_20: prod = prod / 48'(`AIWC_RAW_20MA - `AIWC_RAW_4MA);
         AIWC_I0_20: prod = prod / 48'(`AIWC_RAW_20MA);
         default: prod = prod / 48'(`AIWC_RAW_10V);
      endcase
      return lo + prod[31:0];
   endfunction : scale
   logic [15:0] raw_a, raw_b, sat;
   logic v1_q, v2_q, anom_q, diag_q;
   logic signed [31:0] a_q, b_q;
   assign sat = ctrl_q[`AIWC_F_SAT25] ? `AIWC_RAW_SAT : 16'h0;
   assign raw_a = SAMPLE.anomaly[ch_a] ? sat : SAMPLE.raw[ch_a];
   assign raw_b = SAMPLE.anomaly[ch_b] ? sat : SAMPLE.raw[ch_b];
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         v1_q <= 1'b0;
         a_q <= 32'sh0;
         b_q <= 32'sh0;
         anom_q <= 1'b0;
         diag_q <= 1'b0;
      end else begin
         v1_q <= SAMPLE.valid;
         if (SAMPLE.valid) begin
            a_q <= scale(raw_a, typ, smin_q, smax_q);
            b_q <= ctrl_q[`AIWC_F_DIFF] ? scale(raw_b, typ, smin2_q, smax2_q)
                                        : scale(raw_b, typ, smin_q, smax_q);
            anom_q <= SAMPLE.anomaly[ch_a] | (redundant & SAMPLE.anomaly[ch_b]);
            // Voltage sensors have no lower limit
            diag_q <= raw_a > limit_q[31:16] |
                      (typ != AIWC_V0_10 && raw_a < limit_q[15:0]) |
                      (redundant & (raw_b > limit_q[31:16] |
                      (typ != AIWC_V0_10 && raw_b < limit_q[15:0])));
         end
      end
   end

   // ----------------------------------------
   // Stage 2: coherence and consolidation
   // ----------------------------------------
   logic signed [31:0] cons_q, diff;
   logic signed [32:0] sum;
   logic dev_over_q;
   assign diff = (a_q > b_q) ? a_q - b_q : b_q - a_q;
   assign sum = 33'(a_q) + 33'(b_q);
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         v2_q <= 1'b0;
         cons_q <= 32'sh0;
         dev_over_q <= 1'b0;
      end else begin
         v2_q <= v1_q;
         if (v1_q) begin
            dev_over_q <= redundant && diff > $signed(dev_q);
            if (!redundant) begin
               cons_q <= a_q;
            end else begin
               unique case (aiwc_cons_t'(ctrl_q[`AIWC_F_CONS]))
                  AIWC_C_RED: cons_q <= b_q;
                  AIWC_C_MAX: cons_q <= (a_q > b_q) ? a_q : b_q;
                  AIWC_C_MIN: cons_q <= (a_q < b_q) ? a_q : b_q;
                  AIWC_C_AVG: cons_q <= sum[32:1];
                  default: cons_q <= a_q;
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // Incoherence timer, millisecond ticks
   // ----------------------------------------
   logic [$clog2(TICK_CYC)-1:0] tick_cnt_q;
   logic [31:0] ms_q;
   logic incoh_q;
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         tick_cnt_q <= '0;
         ms_q <= 32'h0;
         incoh_q <= 1'b0;
      end else if (!dev_over_q) begin
         tick_cnt_q <= '0;
         ms_q <= 32'h0;
         incoh_q <= 1'b0;
      end else begin
         if (tick_cnt_q == $bits(tick_cnt_q)'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            if (ms_q != 32'hffff_ffff) ms_q <= ms_q + 32'h1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
         end
         incoh_q <= ms_q > tmo_q;
      end
   end

   // ----------------------------------------
   // Stage 3: comparators and outputs
   // ----------------------------------------
   aiwc_win_t win_q;
   aiwc_thr_t t1_q, t2_q;
   logic signed [31:0] m;
   logic win_en;
   assign m = cons_q;
   assign win_en = ctrl_q[`AIWC_F_WIN];
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         win_q <= AIWC_OUT_WIN;
      end else if (!win_en) begin
         win_q <= AIWC_OUT_WIN;
      end else if (v2_q) begin
         unique case (win_q)
            AIWC_OUT_WIN: if (m > $signed(wlo_q) && m < $signed(whi_q - hyst_q)) begin
               win_q <= AIWC_IN_WIN;
            end
            AIWC_IN_WIN: if (!(m < $signed(whi_q) && m > $signed(wlo_q + hyst_q))) begin
               win_q <= AIWC_OUT_WIN;
            end
         endcase
      end
   end
   function automatic aiwc_thr_t thr_next(input aiwc_thr_t s, input logic signed [31:0] v,
         input logic signed [31:0] th, input logic signed [31:0] hy);
      if (s == AIWC_UNDER) return (v > th) ? AIWC_OVER : AIWC_UNDER;
      return (v < th - hy) ? AIWC_UNDER : AIWC_OVER;
   endfunction : thr_next
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         t1_q <= AIWC_UNDER;
         t2_q <= AIWC_UNDER;
      end else begin
         if (win_en || !ctrl_q[`AIWC_F_THR1]) begin
            t1_q <= AIWC_UNDER;
         end else if (v2_q) begin
            t1_q <= thr_next(t1_q, m, thr1_q, hyst_q);
         end
         if (win_en || !ctrl_q[`AIWC_F_THR2]) begin
            t2_q <= AIWC_UNDER;
         end else if (v2_q) begin
            t2_q <= thr_next(t2_q, m, thr2_q, hyst_q);
         end
      end
   end
   // Outputs lag the state flops one cycle; keeps every port on a flop
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ANALOG_DATA <= 32'h0;
         ANALOG_VALID <= 1'b0;
         COMPARATOR_OUTPUT_ONE <= 1'b0;
         COMPARATOR_OUTPUT_TWO <= 1'b0;
         ERROR_OUT <= 1'b0;
         DIAG_OUT <= 1'b0;
         INCOHERENT_OUT <= 1'b0;
      end else begin
         ANALOG_VALID <= v2_q;
         if (v2_q) ANALOG_DATA <= cons_q;
         COMPARATOR_OUTPUT_ONE <= win_en ? (win_q == AIWC_IN_WIN) : (t1_q == AIWC_OVER);
         COMPARATOR_OUTPUT_TWO <= t2_q == AIWC_OVER;
         ERROR_OUT <= ctrl_q[`AIWC_F_ERREN] & anom_q;
         DIAG_OUT <= diag_q | incoh_q;
         INCOHERENT_OUT <= incoh_q;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   property p_win_enter;
      win_en && v2_q && win_q == AIWC_OUT_WIN && m > $signed(wlo_q)
         && m < $signed(whi_q - hyst_q) ##1 win_en |-> win_q == AIWC_IN_WIN;
   endproperty
   a_win_enter: assert property (p_win_enter) else $error("window not entered");
   property p_win_leave;
      win_en && v2_q && win_q == AIWC_IN_WIN && m >= $signed(whi_q) |=> win_q == AIWC_OUT_WIN;
   endproperty
   a_win_leave: assert property (p_win_leave) else $error("window not left");
   property p_win_out;
      win_en && win_q == AIWC_IN_WIN |=> COMPARATOR_OUTPUT_ONE;
   endproperty
   a_win_out: assert property (p_win_out) else $error("window output wrong");
   property p_excl;
      win_en ##1 win_en |-> t1_q == AIWC_UNDER && t2_q == AIWC_UNDER;
   endproperty
   a_excl: assert property (p_excl) else $error("thresholds active with window");
   property p_thr_up;
      !win_en && ctrl_q[`AIWC_F_THR1] && v2_q && m > $signed(thr1_q) ##1 !win_en
         && ctrl_q[`AIWC_F_THR1] |-> t1_q == AIWC_OVER;
   endproperty
   a_thr_up: assert property (p_thr_up) else $error("threshold not crossed");
   property p_data;
      v2_q |=> ANALOG_VALID && ANALOG_DATA == $past(cons_q);
   endproperty
   a_data: assert property (p_data) else $error("analog data mismatch");
   property p_err;
      SAMPLE.valid && SAMPLE.anomaly[ch_a] && ctrl_q[`AIWC_F_ERREN] ##1
         ctrl_q[`AIWC_F_ERREN] |=> ERROR_OUT;
   endproperty
   a_err: assert property (p_err) else $error("error output missing");
   property p_cons_max;
      v1_q && redundant && ctrl_q[`AIWC_F_CONS] == 3'h2 |=> cons_q >= $past(a_q)
         && cons_q >= $past(b_q);
   endproperty
   a_cons_max: assert property (p_cons_max) else $error("maximum wrong");
   property p_incoh;
      incoh_q |-> $past(dev_over_q);
   endproperty
   a_incoh: assert property (p_incoh) else $error("incoherence without deviation");
   c_in_window: cover property (win_q == AIWC_OUT_WIN ##1 win_q == AIWC_IN_WIN);
   c_over: cover property (t1_q == AIWC_OVER);
   c_incoh: cover property (INCOHERENT_OUT);
   c_error: cover property (ERROR_OUT);
endmodule : aiwc_block

/* tb/aiwc_sensor_model.sv */
// Sensor side model: four analog channels handing samples to the block.
// Assumes the bench raises send one clock ahead of each wanted sample.
`timescale 1ns/100ps
module aiwc_sensor_model import aiwc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic send,
   input wire logic [3:0][15:0] level,
   input wire logic [3:0] fault,
   output aiwc_samp_t samp
);
   // ----------------------------------------
   // Conversion output
   // ----------------------------------------
   // Data toggles between samples so stale values never pass as fresh
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         samp <= '0;
      end else if (send) begin
         samp.valid <= 1'b1;
         samp.raw <= level;
         samp.anomaly <= fault;
      end else begin
         samp.valid <= 1'b0;
         samp.raw <= ~samp.raw;
         samp.anomaly <= ~samp.anomaly;
      end
   end
endmodule : aiwc_sensor_model

/* tb/aiwc_block_bench.sv */
// Self-checking bench of the analog input block: APB set-up, samples, output checks.
// Assumes the package, the parameter header and the sensor model compiled first.
`timescale 1ns/100ps
`include "aiwc_params.svh"
module aiwc_block_bench import aiwc_pkg::*; ;
   logic mclk, reset, psel, penable, pwrite, send;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, analog_data;
   logic pready, pslverr, analog_valid, cmp1, cmp2, err_out, diag_out, incoh_out;
   logic [3:0][15:0] level;
   logic [3:0] fault;
   aiwc_samp_t samp;
   int mismatches, num_checks;

   // ----------------------------------------
   // Instances
   // ----------------------------------------
   // Short tick keeps timeout runs to a few dozen cycles
   aiwc_block #(.TICK_CYC(4)) aiwc_block_inst (
      .MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SAMPLE(samp), .ANALOG_DATA(analog_data), .ANALOG_VALID(analog_valid),
      .COMPARATOR_OUTPUT_ONE(cmp1), .COMPARATOR_OUTPUT_TWO(cmp2), .ERROR_OUT(err_out),
      .DIAG_OUT(diag_out), .INCOHERENT_OUT(incoh_out));
   aiwc_sensor_model aiwc_sensor_model_inst (
      .clk(mclk), .rst(reset), .send(send), .level(level), .fault(fault), .samp(samp));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
      num_checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, expv, seen);
      end
   endtask : check

   task automatic stall(input string what);
      mismatches++;
      $display("mismatch %s expected handshake seen none", what);
      summarize;
   endtask : stall

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) stall("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] expv, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, expv);
   endtask : rd

   // Returns with comparator outputs of this sample settled
   task automatic take(input logic [3:0][15:0] lv, input logic [3:0] fl);
      int n;
      level <= lv;
      fault <= fl;
      send <= 1'b1;
      @(posedge mclk);
      send <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (analog_valid !== 1'b1 && n < 10);
      if (n >= 10) stall("analog valid");
      repeat (2) @(posedge mclk);
   endtask : take

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rd(`AIWC_CTRL, 32'h0, "ctrl reset");
      rd(`AIWC_LIMIT, 32'h59d8_09c4, "limit reset");
      rd(`AIWC_SMAX, 32'h0000_03e8, "smax reset");
      apb(1'b1, 8'h3c, 32'h1234_5678, r, e);
      check("unmapped error", {31'h0, e}, 32'h1);
      apb(1'b0, 8'h3c, 32'h0, r, e);
      check("unmapped data", r, 32'h0);
   endtask : t_regs

   task automatic t_scale;
      int ty[6] = '{0, 0, 0, 1, 1, 2};
      int ch[6] = '{0, 3, 1, 2, 3, 1};
      int rw[6] = '{4000, 20000, 12000, 0, 10000, 10000};
      int ex[6] = '{0, 1000, 500, 0, 500, 1000};
      logic [3:0][15:0] lv;
      for (int i = 0; i < 6; i++) begin
         lv = {4{16'h1e61}};
         lv[ch[i]] = 16'(rw[i]);
         wr(`AIWC_CTRL, 32'(ty[i] | (ch[i] << 2)));
         take(lv, 4'h0);
         check("scaled", analog_data, 32'(ex[i]));
      end
   endtask : t_scale

   task automatic t_cons;
      int a, b, ex;
      logic [3:0][15:0] lv;
      wr(`AIWC_DEV, 32'h0000_03e8);
      for (int p = 0; p < 2; p++) begin
         a = p ? 301 : 200;
         b = p ? 200 : 301;
         lv = {4{16'h2222}};
         lv[2 * p] = 16'(a * 20);
         lv[2 * p + 1] = 16'(b * 20);
         for (int c = 0; c < 5; c++) begin
            ex = c == 0 ? a : c == 1 ? b : (a + b) / 2;
            if (c == 2) ex = a > b ? a : b;
            if (c == 3) ex = a < b ? a : b;
            wr(`AIWC_CTRL, 32'(1 | (1 << (4 + p)) | (2 * p << 2) | (c << 7)));
            take(lv, 4'h0);
            check("consolidated", analog_data, 32'(ex));
         end
      end
      rd(`AIWC_VALUE, 32'(ex), "value register");
   endtask : t_cons

   task automatic t_diff;
      wr(`AIWC_SMAX2, 32'h0000_07d0);
      wr(`AIWC_DEV, 32'h0);
      wr(`AIWC_CTRL, 32'h0000_00d1);
      take({16'h0, 16'h0, 16'h0bb8, 16'h1770}, 4'h0);
      check("rescaled second", analog_data, 32'd300);
      check("no incoherence", {31'h0, incoh_out}, 32'h0);
   endtask : t_diff

   task automatic t_coh;
      int n;
      wr(`AIWC_DEV, 32'h0000_000a);
      wr(`AIWC_TMO, 32'h0000_0002);
      wr(`AIWC_CTRL, 32'h0000_0011);
      level <= {16'h0, 16'h0, 16'h1068, 16'h0fa0};
      send <= 1'b1;
      repeat (40) @(posedge mclk);
      check("incoherent at limit", {31'h0, incoh_out}, 32'h0);
      level <= {16'h0, 16'h0, 16'h107c, 16'h0fa0};
      repeat (6) @(posedge mclk);
      check("incoherent early", {31'h0, incoh_out}, 32'h0);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (incoh_out !== 1'b1 && n < 40);
      if (n >= 40) stall("incoherent");
      check("diag on incoherence", {31'h0, diag_out}, 32'h1);
      rd(`AIWC_STATUS, 32'h0000_0031, "status incoherent");
      level <= {16'h0, 16'h0, 16'h1068, 16'h0fa0};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (incoh_out !== 1'b0 && n < 16);
      if (n >= 16) stall("coherent again");
      send <= 1'b0;
      @(posedge mclk);
   endtask : t_coh

   task automatic t_window;
      int v[9] = '{100, 480, 479, 499, 500, 300, 120, 121, 110};
      int e[9] = '{0, 0, 1, 1, 0, 1, 0, 1, 0};
      wr(`AIWC_WLO, 32'd100);
      wr(`AIWC_WHI, 32'd500);
      wr(`AIWC_HYST, 32'd20);
      wr(`AIWC_THR2, 32'd50);
      wr(`AIWC_CTRL, 32'h0000_1401);
      for (int i = 0; i < 9; i++) begin
         take({{3{16'h0}}, 16'(v[i] * 20)}, 4'h0);
         check("window out", {31'h0, cmp1}, 32'(e[i]));
         check("second out", {31'h0, cmp2}, 32'h0);
         check("window data", analog_data, 32'(v[i]));
      end
   endtask : t_window

   task automatic t_thresh;
      int v[7] = '{300, 301, 281, 279, 601, 581, 579};
      int e1[7] = '{0, 1, 1, 0, 1, 1, 1};
      int e2[7] = '{0, 0, 0, 0, 1, 1, 0};
      wr(`AIWC_THR1, 32'd300);
      wr(`AIWC_THR2, 32'd600);
      wr(`AIWC_CTRL, 32'h0000_1801);
      for (int i = 0; i < 7; i++) begin
         take({{3{16'h0}}, 16'(v[i] * 20)}, 4'h0);
         check("threshold one", {31'h0, cmp1}, 32'(e1[i]));
         check("threshold two", {31'h0, cmp2}, 32'(e2[i]));
      end
   endtask : t_thresh

   task automatic t_anom;
      int ct[7] = '{'h4000, 'h4000, 'h4000, 'h4000, 'h6000, 'h2000, 'h4000};
      int rw[7] = '{2400, 2500, 23001, 12000, 12000, 12000, 12000};
      int fl[7] = '{0, 0, 0, 1, 1, 1, 2};
      int ee[7] = '{0, 0, 0, 1, 1, 0, 0};
      int ed[7] = '{1, 0, 1, 2, 2, 2, 2};
      int x;
      for (int i = 0; i < 7; i++) begin
         x = fl[i][0] ? ((ct[i] & 'h2000) ? 25000 : 0) : rw[i];
         wr(`AIWC_CTRL, 32'(ct[i]));
         take({{3{16'h1f40}}, 16'(rw[i])}, 4'(fl[i]));
         check("anomaly data", analog_data, 32'((x - 4000) * 1000 / 16000));
         check("error out", {31'h0, err_out}, 32'(ee[i]));
         if (ed[i] < 2) check("limit diag", {31'h0, diag_out}, 32'(ed[i]));
      end
   endtask : t_anom

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      send = 1'b0;
      level = '0;
      fault = 4'h0;
      mismatches = 0;
      num_checks = 0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_regs;
      t_scale;
      t_cons;
      t_diff;
      t_coh;
      t_window;
      t_thresh;
      t_anom;
      summarize;
   end
endmodule : aiwc_block_bench
